// >>> verilog/cfg_readout_pkg.sv
// Purpose: shared types and constants for the serial configuration read-out block
// Assumes: 40 MHz core clock; 20-bit word address with 16 bits per word
// Notes:   all widths, offsets and timing counts live here; reset values sit in the core register

package cfg_readout_pkg;

  // ****************************************************************
  // geometry of the store
  // ****************************************************************
  localparam int unsigned ADDR_W      = 20;              // word address width
  localparam int unsigned BIT_W       = 4;               // bit position within a word
  localparam int unsigned WORD_W      = 16;              // bits per stored word
  localparam int unsigned PAGE_SHIFT  = 18;              // bank select sits above this
  localparam logic [ADDR_W-1:0] PAGE_BASE_0  = 20'h00000;
  localparam logic [ADDR_W-1:0] PAGE_BASE_1  = 20'h40000;
  localparam logic [ADDR_W-1:0] PAGE_BASE_2  = 20'h80000;
  localparam logic [ADDR_W-1:0] PAGE_BASE_3  = 20'hC0000;
  localparam logic [ADDR_W-1:0] PAGE_TOP_OFS = 20'h3FFFF; // last word of any page
  localparam logic [ADDR_W-1:0] DEVICE_BASE  = 20'h00000;
  localparam logic [ADDR_W-1:0] DEVICE_TOP   = 20'hFFFFF;
  localparam logic [BIT_W-1:0]  LAST_BIT     = 4'hF;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CORE_PERIOD_NS  = 25;
  localparam int unsigned POWERUP_NS      = 1000;        // power-up reset hold time
  localparam int unsigned POWERUP_CYCLES  = (POWERUP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned PU_CNT_W        = 6;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic       reset_oe;               // low: reset, high: output enable
    logic       chip_select_n;
    logic       page_en;
    logic [1:0] bank_select;
    logic       program_mode_n;         // low selects two-wire programming
    logic       program_device_select;
  } pins_t;

  // control handed from the core domain to the link domain
  typedef struct packed {
    logic       clear;
    logic       run;
    logic       page_en;
    logic [1:0] bank_select;
  } link_ctrl_t;

  typedef struct packed {
    pins_t              pin_meta;
    pins_t              pin_sync;
    logic               done_meta;
    logic               done_sync;
    logic [PU_CNT_W-1:0] pu_cnt;
    logic               powered;
    link_ctrl_t         ctrl;
    logic               data_oe_n;
    logic               cascade_n;
    logic               standby;
    logic               prog_sel;
    logic               ready_oe_n;
    logic               clk_oe_n;
  } core_state_t;

  typedef struct packed {
    logic               rst_meta;
    logic               rst_sync;
    link_ctrl_t         ctrl_meta;
    link_ctrl_t         ctrl_sync;
    logic [ADDR_W-1:0]  addr;
    logic [BIT_W-1:0]   bitpos;
    logic               done;
    logic               data;
  } link_state_t;

endpackage : cfg_readout_pkg

// >>> verilog/serial_config_readout.sv
// Purpose: read-out logic of a serial configuration memory feeding an FPGA
// Assumes: control pins are asynchronous; the serial clock comes from the FPGA
// Notes:   stored words are fetched over a word-wide port, shifted out LSB first

`timescale 1ns/10ps
`default_nettype none

module serial_config_readout
  import cfg_readout_pkg::*;
(
  // core clock and reset
  input  wire logic                CORE_CLK_IN,
  input  wire logic                SYS_RST_IN,
  // serial clock from the FPGA, clocks the link side
  input  wire logic                SERIAL_CLOCK_PIN_IN,
  output var  logic                SERIAL_CLOCK_PIN_OE_N_OUT,
  // control pins
  input  wire logic                RESET_OE_IN,
  input  wire logic                CHIP_SELECT_N_IN,
  input  wire logic                PAGE_EN_IN,
  input  wire logic [1:0]          BANK_SELECT_IN,
  input  wire logic                PROGRAM_MODE_N_IN,
  input  wire logic                PROGRAM_DEVICE_SELECT_IN,
  // data pin
  input  wire logic                DATA_IN,
  output var  logic                DATA_OUT,
  output var  logic                DATA_OE_N_OUT,
  // stored word port, link clock domain
  output var  logic [ADDR_W-1:0]   MEM_ADDR_OUT,
  input  wire logic [WORD_W-1:0]   MEM_WORD_IN,
  // status
  output var  logic                CASCADE_OUT_N_OUT,
  output var  logic                READY_OE_N_OUT,
  output var  logic                STANDBY_OUT,
  output var  logic                PROGRAM_SELECTED_OUT
);

  // ****************************************************************
  // decoding used by the link domain and its assertions
  // ****************************************************************

  // first word of the download area
  function automatic logic [ADDR_W-1:0] area_base(input logic pg, input logic [1:0] bank);
    logic [ADDR_W-1:0] b;
    b = DEVICE_BASE;
    if (pg) begin
      case (bank)
        2'h0:    b = PAGE_BASE_0;
        2'h1:    b = PAGE_BASE_1;
        2'h2:    b = PAGE_BASE_2;
        default: b = PAGE_BASE_3;
      endcase
    end
    return b;
  endfunction : area_base

  // last word of the download area
  function automatic logic [ADDR_W-1:0] area_top(input logic pg, input logic [1:0] bank);
    logic [ADDR_W-1:0] t;
    t = pg ? (area_base(pg, bank) | PAGE_TOP_OFS) : DEVICE_TOP;
    return t;
  endfunction : area_top

  // ****************************************************************
  // core domain
  // ****************************************************************
  core_state_t cur;
  core_state_t next_cur;
  link_state_t lnk;
  link_state_t next_lnk;
  pins_t       pins_now;
  logic        readout;
  logic        active;

  assign pins_now = '{reset_oe:              RESET_OE_IN,
                      chip_select_n:         CHIP_SELECT_N_IN,
                      page_en:               PAGE_EN_IN,
                      bank_select:           BANK_SELECT_IN,
                      program_mode_n:        PROGRAM_MODE_N_IN,
                      program_device_select: PROGRAM_DEVICE_SELECT_IN};

  // decoded mode from the synchronised pins
  assign readout = cur.pin_sync.program_mode_n;
  assign active  = cur.powered & readout & cur.pin_sync.reset_oe
                 & ~cur.pin_sync.chip_select_n;

  // next core state
  always_comb begin
    next_cur = cur;
    // two-flop synchronisers: stage one only feeds stage two
    next_cur.pin_meta  = pins_now;
    next_cur.pin_sync  = cur.pin_meta;
    next_cur.done_meta = lnk.done;
    next_cur.done_sync = cur.done_meta;
    // power-up sequencing holds the counters cleared until the count expires
    if (!cur.powered) begin
      next_cur.pu_cnt = cur.pu_cnt + PU_CNT_W'(1);
      if (cur.pu_cnt == PU_CNT_W'(POWERUP_CYCLES - 1)) begin
        next_cur.powered = 1'b1;
      end
    end
    // reset/oe low or no power clears, whatever chip select does
    next_cur.ctrl.clear = ~cur.powered | ~readout | ~cur.pin_sync.reset_oe;
    // select high or programming mode stops the counters
    next_cur.ctrl.run   = active;
    // paging inputs only count in read-out mode
    next_cur.ctrl.page_en     = readout & cur.pin_sync.page_en;
    next_cur.ctrl.bank_select = readout ? cur.pin_sync.bank_select : 2'h0;
    // driver on only while enabled and the area is not yet exhausted
    next_cur.data_oe_n  = ~(active & ~cur.done_sync);
    // cascade: low while selected after the top, follows select, high after reset
    if (readout && cur.powered && cur.done_sync && cur.pin_sync.reset_oe) begin
      next_cur.cascade_n = cur.pin_sync.chip_select_n;
    end else begin
      next_cur.cascade_n = 1'b1;
    end
    next_cur.standby    = readout & cur.pin_sync.chip_select_n;
    next_cur.prog_sel   = ~readout & cur.pin_sync.program_device_select;
    // open-collector ready: pulled low until power-up completes
    next_cur.ready_oe_n = cur.powered;
    // clock pin is an output only during read-out
    next_cur.clk_oe_n   = ~readout;
  end

  // core register, synchronous reset
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      cur            <= '0;
      cur.ctrl.clear <= 1'b1;
      cur.data_oe_n  <= 1'b1;
      cur.cascade_n  <= 1'b1;
      cur.clk_oe_n   <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // link domain, clocked by the serial clock
  // ****************************************************************

  // limitation: the link side runs only on the serial clock, so a reset/oe low
  // level reaches the counters after the third serial edge; a controller that
  // holds the clock still through reset must give those edges before raising
  // output enable, or the stream resumes where it stopped. an asynchronous
  // clear was avoided to keep a single synchronous reset style.
  // next link state; control arrives as quasi-static levels through two flops
  always_comb begin
    next_lnk = lnk;
    next_lnk.rst_meta  = SYS_RST_IN;
    next_lnk.rst_sync  = lnk.rst_meta;
    next_lnk.ctrl_meta = cur.ctrl;
    next_lnk.ctrl_sync = lnk.ctrl_meta;
    if (lnk.rst_sync || lnk.ctrl_sync.clear) begin
      // counters return to the start of the selected area
      next_lnk.addr   = area_base(lnk.ctrl_sync.page_en, lnk.ctrl_sync.bank_select);
      next_lnk.bitpos = '0;
      next_lnk.done   = 1'b0;
      next_lnk.data   = 1'b0;  // pin floats now; a known level keeps the next start clean
    end else if (lnk.ctrl_sync.run && !lnk.done) begin
      // one stored bit per serial clock
      next_lnk.data   = MEM_WORD_IN[lnk.bitpos];
      next_lnk.bitpos = lnk.bitpos + BIT_W'(1);
      if (lnk.bitpos == LAST_BIT) begin
        if (lnk.addr == area_top(lnk.ctrl_sync.page_en, lnk.ctrl_sync.bank_select)) begin
          next_lnk.done = 1'b1;
        end else begin
          next_lnk.addr = lnk.addr + ADDR_W'(1);
        end
      end
    end
  end

  // link register; reset and clear also take effect only on serial edges
  always_ff @(posedge SERIAL_CLOCK_PIN_IN) begin
    lnk <= next_lnk;
  end

  // ****************************************************************
  // outputs, all straight from flip-flops
  // ****************************************************************
  assign SERIAL_CLOCK_PIN_OE_N_OUT = cur.clk_oe_n;
  assign DATA_OUT                  = lnk.data;
  assign DATA_OE_N_OUT             = cur.data_oe_n;
  assign MEM_ADDR_OUT              = lnk.addr;
  assign CASCADE_OUT_N_OUT         = cur.cascade_n;
  assign READY_OE_N_OUT            = cur.ready_oe_n;
  assign STANDBY_OUT               = cur.standby;
  assign PROGRAM_SELECTED_OUT      = cur.prog_sel;

  // ****************************************************************
  // assertions, core domain
  // ****************************************************************
  AST_OE_LOW_FLOATS: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !cur.pin_sync.reset_oe |=> cur.data_oe_n)
    else $error("data driven while reset/oe low");

  AST_OE_LOW_CLEARS: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !cur.pin_sync.reset_oe |=> cur.ctrl.clear && !cur.ctrl.run)
    else $error("counter not cleared by reset/oe low");

  AST_DESELECT_HOLDS: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (readout && cur.pin_sync.chip_select_n) |=> (cur.data_oe_n && !cur.ctrl.run))
    else $error("deselected device counting or driving");

  AST_ENABLE: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (active && !cur.done_sync) |=> (!cur.data_oe_n && cur.ctrl.run && !cur.ctrl.clear))
    else $error("enabled device not driving");

  AST_RESET_WINS: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (!cur.pin_sync.reset_oe && !cur.pin_sync.chip_select_n) |=> (cur.ctrl.clear && cur.data_oe_n))
    else $error("reset lost while selected");

  AST_STANDBY: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (readout && cur.pin_sync.chip_select_n) |=> (cur.standby && cur.data_oe_n))
    else $error("standby not entered");

  AST_PROG_IGNORES_SELECT: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !readout |=> (cur.data_oe_n && !cur.standby && !cur.ctrl.run && !cur.ctrl.page_en))
    else $error("chip select acted in programming mode");

  AST_DONE_FLOATS: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    cur.done_sync |=> cur.data_oe_n)
    else $error("data driven after last bit");

  AST_CASCADE_LOW: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (cur.done_sync && active) |=> !cur.cascade_n)
    else $error("cascade not low after top reached");

  AST_CASCADE_HIGH_AFTER_OE: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !cur.pin_sync.reset_oe |=> cur.cascade_n)
    else $error("cascade low after reset/oe low");

  // ready trails powered by one edge, so the final count sits two samples back
  AST_READY_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    $rose(cur.ready_oe_n) |-> ($past(cur.pu_cnt, 2) == PU_CNT_W'(POWERUP_CYCLES - 1)))
    else $error("ready released at wrong time");

  AST_POWERUP_CLEAR: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !cur.powered |=> cur.ctrl.clear)
    else $error("counter not cleared during power-up");

  AST_PROG_SELECT: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (!readout && cur.pin_sync.program_device_select) |=> cur.prog_sel)
    else $error("device select ignored in programming mode");

  AST_PROG_UNSELECTED: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (!readout && !cur.pin_sync.program_device_select) |=> !cur.prog_sel)
    else $error("selected in programming mode without device select");

  // ****************************************************************
  // assertions, pin roles and status
  // ****************************************************************
  AST_CLK_PIN_OUT: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    readout |=> !cur.clk_oe_n)
    else $error("clock pin not an output in read-out");

  AST_CLK_PIN_IN: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !readout |=> cur.clk_oe_n)
    else $error("clock pin not an input in programming");

  AST_PAGING_IGNORED: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !readout |=> (!cur.ctrl.page_en && cur.ctrl.bank_select == 2'h0))
    else $error("paging inputs acted in programming mode");

  AST_PAGE_FOLLOWS: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    readout |=> (cur.ctrl.page_en == $past(cur.pin_sync.page_en)))
    else $error("paging enable not passed on");

  AST_READY_LOW: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !cur.powered |=> !cur.ready_oe_n)
    else $error("ready released during power-up");

  AST_RUN_NEEDS_POWER: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !cur.powered |=> (!cur.ctrl.run && cur.data_oe_n))
    else $error("counter ran during power-up");

  AST_CASCADE_FOLLOWS: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (readout && cur.powered && cur.done_sync && cur.pin_sync.reset_oe)
    |=> (cur.cascade_n == $past(cur.pin_sync.chip_select_n)))
    else $error("cascade not following select after top");

  AST_PROG_NO_CASCADE: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !readout |=> cur.cascade_n)
    else $error("cascade low in programming mode");

  // ****************************************************************
  // assertions, link domain
  // ****************************************************************
  AST_ADDR_STEP: assert property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    (!lnk.ctrl_sync.clear && lnk.ctrl_sync.run && !lnk.done && lnk.bitpos == LAST_BIT
     && lnk.addr != area_top(lnk.ctrl_sync.page_en, lnk.ctrl_sync.bank_select))
    |=> (lnk.addr == $past(lnk.addr) + ADDR_W'(1)) && (lnk.bitpos == '0))
    else $error("address did not step after last bit of word");

  AST_BIT_STEP: assert property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    (!lnk.ctrl_sync.clear && lnk.ctrl_sync.run && !lnk.done)
    |=> (lnk.bitpos == $past(lnk.bitpos) + BIT_W'(1)))
    else $error("bit position did not advance");

  AST_CLEAR_BASE: assert property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    lnk.ctrl_sync.clear |=> (lnk.addr == area_base($past(lnk.ctrl_sync.page_en),
                                                   $past(lnk.ctrl_sync.bank_select)))
                            && !lnk.done && lnk.bitpos == '0)
    else $error("clear did not load area base");

  AST_DONE_AT_TOP: assert property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    $rose(lnk.done) |-> (lnk.addr == area_top(lnk.ctrl_sync.page_en, lnk.ctrl_sync.bank_select)))
    else $error("done raised below area top");

  AST_DATA_STEADY: assert property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    (!lnk.ctrl_sync.clear && (!lnk.ctrl_sync.run || lnk.done)) |=> $stable(lnk.data))
    else $error("data bit changed while stopped");

  AST_STOPPED_FREEZES: assert property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    (!lnk.ctrl_sync.clear && !lnk.ctrl_sync.run) |=> ($stable(lnk.addr) && $stable(lnk.bitpos)))
    else $error("counters moved while stopped");

  AST_DONE_STAYS: assert property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    (lnk.done && !lnk.ctrl_sync.clear) |=> (lnk.done && $stable(lnk.addr)))
    else $error("counter left the top before a clear");

  AST_BANK_BASE: assert property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    (lnk.ctrl_sync.clear && lnk.ctrl_sync.page_en)
    |=> (lnk.addr[ADDR_W-1:PAGE_SHIFT] == $past(lnk.ctrl_sync.bank_select)))
    else $error("paged clear did not land on the bank base");

  // ****************************************************************
  // covers
  // ****************************************************************
  COV_CASCADE: cover property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    $fell(cur.cascade_n));

  COV_PAGED_RUN: cover property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    lnk.ctrl_sync.run && lnk.ctrl_sync.page_en && lnk.ctrl_sync.bank_select == 2'h3);

  COV_STANDBY: cover property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    $rose(cur.standby));

  COV_PROG_MODE: cover property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    $rose(cur.prog_sel));

  COV_WORD_STEP: cover property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (lnk.rst_sync)
    lnk.ctrl_sync.run && !lnk.done && lnk.bitpos == LAST_BIT);

endmodule : serial_config_readout

`default_nettype wire

// >>> verif/fpga_loader_model.sv
// Purpose: far-side model, the configuration controller and the select line of the next store of the chain
// Assumes: the controller makes the serial clock and stops it low between frames
// Notes:   the data pin has a pull-up, so a floating pin reads high
`timescale 1ns/10ps
`default_nettype none
module fpga_loader_model (
  // control from the bench
  input  wire logic clk_run_in,
  // pins of the store
  input  wire logic data_out_in,
  input  wire logic data_oe_n_in,
  input  wire logic cascade_n_in,
  output var  logic serial_clock_out,
  output wire logic data_line_out,
  output wire logic next_chip_select_n_out
);
  logic bits [$];
  // pull-up wins whenever the store floats its pin
  assign data_line_out = data_oe_n_in ? 1'b1 : data_out_in;
  // cascade drives the select of the next store
  assign next_chip_select_n_out = cascade_n_in;
  initial serial_clock_out = 1'b0;
  // odd offset keeps the rising serial edges off the core grid; always ends a period low
  always begin
    wait (clk_run_in === 1'b1);
    #43 serial_clock_out = 1'b1;
    #37 serial_clock_out = 1'b0;
  end
  // take each driven bit halfway through its period, where it has settled
  always @(negedge serial_clock_out) begin
    if (data_oe_n_in === 1'b0) begin
      bits.push_back(data_line_out);
    end
  end
endmodule : fpga_loader_model
`default_nettype wire

// >>> verif/serial_config_readout_bench.sv
// Purpose: self-checking bench for the serial configuration read-out block
// Assumes: the store is a bench function of the word address, salted at random
// Notes:   a full page is far too long to read, so the top of the area is not reached
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, (exp), (got)); end end
module serial_config_readout_bench
  import cfg_readout_pkg::*;
();
  logic              core_clk = 1'b0;
  logic              sys_rst, reset_oe, chip_select_n, page_en, program_mode_n, prog_dev_sel, clk_run;
  logic [1:0]        bank_select;
  logic [15:0]       salt;
  wire logic         sclk, data_line, next_cs_n;
  logic              sclk_oe_n, data_out, data_oe_n, cascade_n, ready_oe_n, standby, prog_sel;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_word;
  int                mismatches = 0;
  int                samples_checked = 0;

  // ****************************************************************
  // store model and harness
  // ****************************************************************
  function automatic logic [WORD_W-1:0] word_of(logic [ADDR_W-1:0] a);
    return a[15:0] ^ {4{a[19:16]}} ^ salt;
  endfunction : word_of
  // expected bit i of a stream that starts at base, low bit of each word first
  function automatic logic ebit(logic [ADDR_W-1:0] base, int i);
    logic [WORD_W-1:0] w;
    w = word_of(base + ADDR_W'(i / 16));
    return w[i % 16];
  endfunction : ebit
  assign mem_word = word_of(mem_addr);
  always #12.5 core_clk = ~core_clk;

  serial_config_readout u_serial_config_readout (
    .CORE_CLK_IN(core_clk), .SYS_RST_IN(sys_rst), .SERIAL_CLOCK_PIN_IN(sclk),
    .SERIAL_CLOCK_PIN_OE_N_OUT(sclk_oe_n), .RESET_OE_IN(reset_oe), .CHIP_SELECT_N_IN(chip_select_n),
    .PAGE_EN_IN(page_en), .BANK_SELECT_IN(bank_select), .PROGRAM_MODE_N_IN(program_mode_n),
    .PROGRAM_DEVICE_SELECT_IN(prog_dev_sel), .DATA_IN(data_line), .DATA_OUT(data_out),
    .DATA_OE_N_OUT(data_oe_n), .MEM_ADDR_OUT(mem_addr), .MEM_WORD_IN(mem_word),
    .CASCADE_OUT_N_OUT(cascade_n), .READY_OE_N_OUT(ready_oe_n), .STANDBY_OUT(standby),
    .PROGRAM_SELECTED_OUT(prog_sel));
  fpga_loader_model u_fpga_loader_model (
    .clk_run_in(clk_run), .data_out_in(data_out), .data_oe_n_in(data_oe_n), .cascade_n_in(cascade_n),
    .serial_clock_out(sclk), .data_line_out(data_line), .next_chip_select_n_out(next_cs_n));

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // let the controller clock n serial periods, then stop the clock
  task automatic edges(int n);
    @(posedge core_clk) clk_run <= 1'b1;
    // drop the run request inside the last period so no extra one starts
    repeat (n - 1) @(negedge sclk);
    @(posedge sclk) clk_run <= 1'b0;
    @(negedge sclk);
    cyc(4);
  endtask : edges
  task automatic set_pins(logic roe, logic csn);
    @(posedge core_clk);
    reset_oe      <= roe;
    chip_select_n <= csn;
    cyc(6);
  endtask : set_pins
  // reset pulse long enough in both domains, whatever select is doing
  task automatic clear_pulse();
    set_pins(1'b0, chip_select_n);
    edges(4);
    `CHK("data float in reset", 1'b1, data_oe_n)
  endtask : clear_pulse
  // one download from the area chosen by paging, compared bit by bit
  task automatic frame(logic pe, logic [1:0] bank, int nwords);
    logic [ADDR_W-1:0] base;
    int                found, j, i;
    logic              ok;
    @(posedge core_clk);
    page_en     <= pe;
    bank_select <= bank;
    clear_pulse();
    set_pins(1'b1, 1'b0);
    `CHK("data driven", 1'b0, data_oe_n)
    `CHK("clock pin out", 1'b0, sclk_oe_n)
    `CHK("standby", 1'b0, standby)
    u_fpga_loader_model.bits.delete();
    edges(nwords * 16 + 6);
    base  = pe ? {bank, 18'h00000} : DEVICE_BASE;
    found = -1;
    // the enable crosses into the serial domain, so the first bit lands a few edges in
    for (j = 0; j < 5 && found < 0; j++) begin
      ok = 1'b1;
      for (i = 0; i < 32; i++) ok &= (u_fpga_loader_model.bits[j + i] === ebit(base, i));
      if (ok) found = j;
    end
    `CHK("stream start", 1'b1, found >= 0)
    if (found < 0) found = 0;
    for (i = 0; i < nwords * 16 && i + found < u_fpga_loader_model.bits.size(); i++) begin
      `CHK("serial bit", ebit(base, i), u_fpga_loader_model.bits[found + i])
    end
    `CHK("cascade below top", 1'b1, next_cs_n)
  endtask : frame
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    logic [ADDR_W-1:0] held;
    int                i;
    sys_rst = 1'b1;
    reset_oe = 1'b0;
    chip_select_n = 1'b1;
    page_en = 1'b0;
    bank_select = 2'h0;
    program_mode_n = 1'b1;
    prog_dev_sel = 1'b0;
    clk_run = 1'b1;
    salt = 16'h0000;
    void'($urandom(32'hb6fc6a8a));
    salt = 16'($urandom);
    cyc(3);
    @(negedge core_clk);
    `CHK("ready held low", 1'b0, ready_oe_n)
    `CHK("cascade in reset", 1'b1, cascade_n)
    @(posedge core_clk);
    sys_rst <= 1'b0;
    clk_run <= 1'b0;
    // look between edges so the flag is settled when read
    for (i = 0; i < 60 && ready_oe_n !== 1'b1; i++) @(negedge core_clk);
    `CHK("power-up length", 1'b1, i >= POWERUP_CYCLES && i <= POWERUP_CYCLES + 3)
    cyc(4);
    // enable with select high: counter and driver stay off
    clear_pulse();
    set_pins(1'b1, 1'b1);
    `CHK("off with select high", 1'b1, data_oe_n)
    `CHK("standby entered", 1'b1, standby)
    u_fpga_loader_model.bits.delete();
    edges(20);
    `CHK("no bits sent", 0, u_fpga_loader_model.bits.size())
    for (i = 0; i < 4; i++) frame(1'b1, 2'(i), 2 + $urandom % 3);
    frame(1'b0, 2'($urandom), 3);
    // select high in mid-stream freezes the counter and floats the pin
    set_pins(1'b1, 1'b1);
    `CHK("standby mid-stream", 1'b1, standby)
    `CHK("pin pulled up", 1'b1, data_line)
    edges(3);
    held = mem_addr;
    edges(20);
    `CHK("address frozen", held, mem_addr)
    frame(1'b1, 2'h2, 2);
    // programming mode: select and paging have no say
    @(posedge core_clk);
    program_mode_n <= 1'b0;
    page_en        <= 1'b1;
    set_pins(1'b1, 1'b0);
    `CHK("not selected", 1'b0, prog_sel)
    `CHK("clock pin input", 1'b1, sclk_oe_n)
    `CHK("data float in programming", 1'b1, data_oe_n)
    @(posedge core_clk) prog_dev_sel <= 1'b1;
    set_pins(1'b1, 1'b1);
    `CHK("selected", 1'b1, prog_sel)
    `CHK("no standby in programming", 1'b0, standby)
    summarize();
  end
  // watchdog well past the few tens of microseconds the scenarios take
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
endmodule : serial_config_readout_bench
`default_nettype wire
